// >>> design/cgc_pkg.sv
package cgc_pkg;
  // ***********************************************************
  // register offsets (byte offsets within the register space)
  // ***********************************************************
  localparam logic [17:0] OFS_CONFIG = 18'h00000;
  localparam logic [17:0] OFS_BASE = 18'h00008;
  localparam logic [17:0] OFS_CONTROL = 18'h00010;
  localparam logic [17:0] OFS_CUSTOM = 18'h00068;
  localparam logic [17:0] OFS_ACCESS = 18'h00120;
  localparam logic [17:0] OFS_PFT_A = 18'h00300;
  localparam logic [17:0] OFS_PFT_B = 18'h00308;
  localparam logic [17:0] OFS_SEM = 18'h00640;
  localparam logic [17:0] OFS_COH = 18'h020f8;
  localparam logic [17:0] OFS_COH_STEP = 18'h00100;
  localparam int MAX_CORES = 6;
  localparam int MAX_REQ = 8;
  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int CFG_CORES_LSB = 0;
  localparam int CFG_IOU_LSB = 8;
  localparam int CFG_MMIO_LSB = 16;
  localparam int CFG_AUX_LSB = 20;
  localparam int CFG_CLUS_LSB = 23;
  localparam int CFG_ITC_BIT = 31;
  localparam int CFG_CID_LSB = 32;
  localparam int CFG_DBU_BIT = 40;
  localparam int CFG_NOC_LSB = 41;
  localparam int BASE_LSB = 19;
  localparam int CTL_IOU_LIMIT_BIT = 12;
  localparam int CTL_IOU_BLOCK_BIT = 13;
  localparam int ACC_LSB = 16;
  localparam int PFTA_EN_BIT = 8;
  localparam int PFTB_CEN_BIT = 8;
  localparam int SEMAPHORE_LOCK_BIT_BIT = 31;
  localparam int CUST_PRESENT_BIT = 0;
  localparam int COHERENCE_ENABLE_BIT = 0;
  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [63:0] BASE_RST = 64'h0000_0000_1fb8_0000;
  localparam logic [63:0] ZERO64 = 64'h0;
  // requestor ids on the request path
  localparam logic [3:0] RQ_IOU_FLAG = 4'h8;
endpackage

// >>> design/cgc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cgc_if;
  logic req_valid;
  logic req_write;
  logic [3:0] req_src;
  logic [17:0] req_addr;
  logic [63:0] req_wdata;
  logic rsp_valid;
  logic [63:0] rsp_rdata;
  logic iou_mmio_block;
  logic iou_mmio_count;
  logic pft_enable;
  logic pft_code_en;
  logic [7:0] pft_port_sel;
  logic [5:0] coherence_enable;
  modport dev (
    input req_valid, req_write, req_src, req_addr, req_wdata,
    output rsp_valid, rsp_rdata, iou_mmio_block, iou_mmio_count,
    output pft_enable, pft_code_en, pft_port_sel, coherence_enable
  );
  modport req (
    output req_valid, req_write, req_src, req_addr, req_wdata,
    input rsp_valid, rsp_rdata, iou_mmio_block, iou_mmio_count,
    input pft_enable, pft_code_en, pft_port_sel, coherence_enable
  );
endinterface
`default_nettype wire

// >>> design/cgc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_regs
  import cgc_pkg::*;
#(
  parameter int NUM_CORES = 6,
  parameter int NUM_IOU = 2,
  parameter int NUM_MMIO = 4,
  parameter int NUM_AUX = 4,
  parameter int NUM_CLUSTERS = 1,
  parameter int CLUSTER_ID = 0,
  parameter int NUM_PFT = 1,
  parameter bit ITC_PRESENT = 1'b0,
  parameter bit DBU_PRESENT = 1'b0,
  parameter int NOC_TYPE = 0,
  parameter bit CUSTOM_PRESENT = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // request path
  cgc_if.dev bus
);
  // ***********************************************************
  // build checks
  // ***********************************************************
  if (NUM_CORES > MAX_CORES || NUM_CORES + NUM_IOU > MAX_REQ) begin : g_req
    $error("bad requestor count");
  end
  if (NUM_PFT > 255 || NUM_CLUSTERS > 127 || CLUSTER_ID > 255) begin : g_cfg
    $error("bad config value");
  end
  if (NUM_MMIO > 15 || NUM_AUX > 7 || NOC_TYPE > 7) begin : g_fld
    $error("bad config value");
  end

  // ***********************************************************
  // configuration word
  // ***********************************************************
  wire logic [63:0] cfg_word;
  assign cfg_word = {20'h0, 3'(NOC_TYPE), DBU_PRESENT, 8'(CLUSTER_ID),
    ITC_PRESENT, 1'b0, 7'(NUM_CLUSTERS), 3'(NUM_AUX), 4'(NUM_MMIO),
    4'h0, 4'(NUM_IOU), 8'(NUM_CORES)};

  // ***********************************************************
  // decode
  // ***********************************************************
  logic [63:0] base_q;
  logic [1:0] ctl_q;
  logic [7:0] acc_q;
  logic prefetch_enable_bit_q;
  logic cen_q;
  logic [7:0] port_q;
  logic [31:0] sem_q;
  logic [5:0] coh_q;
  logic [63:0] rdata_q;
  logic rvalid_q;

  wire logic wr;
  wire logic rd_req;
  wire logic is_iou;
  wire logic iou_ok;
  wire logic [2:0] iou_idx;
  wire logic ctl_wr_ok;
  wire logic sem_drop;
  wire logic [17:0] coh_rel;
  wire logic coh_hit;
  wire logic [2:0] coh_idx;
  wire logic [7:0] port_mask;
  logic [63:0] rd_mux;

  assign wr = bus.req_valid && bus.req_write;
  assign rd_req = bus.req_valid && !bus.req_write;
  assign is_iou = bus.req_src[3];
  assign iou_idx = bus.req_src[2:0];
  assign iou_ok = acc_q[iou_idx];
  assign ctl_wr_ok = !is_iou || iou_ok;
  assign sem_drop = bus.req_wdata[SEMAPHORE_LOCK_BIT_BIT] &&
    sem_q[SEMAPHORE_LOCK_BIT_BIT];
  assign coh_rel = bus.req_addr - OFS_COH;
  assign coh_hit = bus.req_addr >= OFS_COH && coh_rel[7:0] == 8'h00 &&
    coh_rel[17:8] < 10'(NUM_CORES);
  assign coh_idx = coh_rel[10:8];
  assign port_mask = 8'((9'h1 << (NUM_CORES + NUM_IOU)) - 9'h1);

  always_comb begin
    rd_mux = ZERO64;
    if (coh_hit) begin
      rd_mux[COHERENCE_ENABLE_BIT] = coh_q[coh_idx];
    end else begin
      case (bus.req_addr)
        OFS_CONFIG: rd_mux = cfg_word;
        OFS_BASE: rd_mux = base_q;
        OFS_CONTROL: begin
          rd_mux[CTL_IOU_LIMIT_BIT] = ctl_q[0];
          rd_mux[CTL_IOU_BLOCK_BIT] = ctl_q[1];
        end
        OFS_CUSTOM: rd_mux[CUST_PRESENT_BIT] = CUSTOM_PRESENT;
        OFS_ACCESS: rd_mux[ACC_LSB +: 8] = acc_q;
        OFS_PFT_A: begin
          rd_mux[7:0] = 8'(NUM_PFT);
          rd_mux[PFTA_EN_BIT] = prefetch_enable_bit_q;
        end
        OFS_PFT_B: begin
          rd_mux[7:0] = port_q;
          rd_mux[PFTB_CEN_BIT] = cen_q;
        end
        OFS_SEM: rd_mux[31:0] = sem_q;
        default: rd_mux = ZERO64;
      endcase
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      base_q <= BASE_RST;
      ctl_q <= 2'h0;
      acc_q <= 8'h00;
      prefetch_enable_bit_q <= 1'b0;
      cen_q <= 1'b0;
      port_q <= 8'h00;
      sem_q <= 32'h0;
      coh_q <= 6'h00;
    end else if (wr) begin
      if (coh_hit) begin
        coh_q[coh_idx] <= bus.req_wdata[COHERENCE_ENABLE_BIT];
      end
      case (bus.req_addr)
        OFS_BASE: begin
          base_q <= {16'h0, bus.req_wdata[47:BASE_LSB],
            19'h0};
        end
        OFS_CONTROL: begin
          if (ctl_wr_ok) begin
            ctl_q <= {bus.req_wdata[CTL_IOU_BLOCK_BIT],
              bus.req_wdata[CTL_IOU_LIMIT_BIT]};
          end
        end
        OFS_ACCESS: begin
          if (ctl_wr_ok) begin
            acc_q <= bus.req_wdata[ACC_LSB +: 8];
          end
        end
        OFS_PFT_A: prefetch_enable_bit_q <= bus.req_wdata[PFTA_EN_BIT];
        OFS_PFT_B: begin
          port_q <= bus.req_wdata[7:0] & port_mask;
          cen_q <= bus.req_wdata[PFTB_CEN_BIT];
        end
        OFS_SEM: begin
          if (!sem_drop) begin
            sem_q <= bus.req_wdata[31:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= ZERO64;
    end else begin
      rvalid_q <= rd_req;
      rdata_q <= rd_req ? rd_mux : ZERO64;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign bus.rsp_valid = rvalid_q;
  assign bus.rsp_rdata = rdata_q;
  assign bus.iou_mmio_block = ctl_q[1];
  assign bus.iou_mmio_count = ctl_q[0] && !ctl_q[1];
  assign bus.pft_enable = prefetch_enable_bit_q && (NUM_PFT != 0);
  assign bus.pft_code_en = cen_q;
  assign bus.pft_port_sel = port_q;
  assign bus.coherence_enable = coh_q;
endmodule
`default_nettype wire

// >>> design/cgc_req.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_req
  import cgc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // software port
  input wire logic [17:0] sw_addr,
  input wire logic [63:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [3:0] sw_src,
  output logic [63:0] sw_rdata,
  output logic sem_acquired,
  // register path
  cgc_if.req bus
);
  // ***********************************************************
  // request drive and readback
  // ***********************************************************
  logic [31:0] sem_wr_q;
  logic sem_rd_q;
  logic acq_q;

  assign bus.req_valid = sw_wr || sw_rd;
  assign bus.req_write = sw_wr;
  assign bus.req_src = sw_src;
  assign bus.req_addr = sw_addr;
  assign bus.req_wdata = sw_wdata;
  assign sw_rdata = bus.rsp_rdata;
  assign sem_acquired = acq_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sem_wr_q <= 32'h0;
      sem_rd_q <= 1'b0;
      acq_q <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == OFS_SEM) begin
        sem_wr_q <= sw_wdata[31:0];
      end
      sem_rd_q <= sw_rd && sw_addr == OFS_SEM;
      if (sem_rd_q && bus.rsp_valid) begin
        acq_q <= sem_wr_q[SEMAPHORE_LOCK_BIT_BIT] &&
          bus.rsp_rdata[31:0] == sem_wr_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/cgc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_assertions
  import cgc_pkg::*;
#(
  parameter int NUM_CORES = 6,
  parameter int NUM_IOU = 2,
  parameter int NUM_PFT = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // request path
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_src,
  input wire logic [17:0] req_addr,
  input wire logic [63:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [63:0] rsp_rdata,
  // control outputs
  input wire logic iou_mmio_block,
  input wire logic iou_mmio_count,
  input wire logic pft_enable,
  input wire logic pft_code_en,
  input wire logic [7:0] pft_port_sel,
  input wire logic [5:0] coherence_enable
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire rd = req_valid && !req_write;
  wire wc = req_valid && req_write && !req_src[3];
  wire [7:0] port_mask = 8'((1 << (NUM_CORES + NUM_IOU)) - 1);
  a_read_answer: assert property (rsp_valid == $past(rd))
    else $error("read answer timing wrong");
  a_cfg_cores: assert property (
    rd && req_addr == OFS_CONFIG |=> rsp_rdata[7:0] == 8'(NUM_CORES))
    else $error("core count field wrong");
  a_cfg_iou: assert property (
    rd && req_addr == OFS_CONFIG |=> rsp_rdata[11:8] == 4'(NUM_IOU))
    else $error("io unit count field wrong");
  a_base_align: assert property (
    rd && req_addr == OFS_BASE |=> rsp_rdata[18:0] == 19'h0)
    else $error("base not aligned");
  a_mmio_block: assert property (
    wc && req_addr == OFS_CONTROL |=> iou_mmio_block == $past(req_wdata[13]))
    else $error("mmio block wrong");
  a_mmio_count: assert property (
    wc && req_addr == OFS_CONTROL |=>
    iou_mmio_count == ($past(req_wdata[12]) && !$past(req_wdata[13])))
    else $error("mmio count wrong");
  a_pft_enable: assert property (
    wc && req_addr == OFS_PFT_A |=>
    pft_enable == ($past(req_wdata[8]) && NUM_PFT > 0))
    else $error("prefetch enable wrong");
  a_port_sel: assert property (
    wc && req_addr == OFS_PFT_B |=>
    pft_port_sel == ($past(req_wdata[7:0]) & port_mask))
    else $error("port select wrong");
  a_code_pref: assert property (
    wc && req_addr == OFS_PFT_B |=> pft_code_en == $past(req_wdata[8]))
    else $error("code prefetch wrong");
  a_coh_core0: assert property (
    wc && req_addr == OFS_COH |=> coherence_enable[0] == $past(req_wdata[0]))
    else $error("coherence enable wrong");
  c_sem_read: cover property (rd && req_addr == OFS_SEM);
  c_iou_write: cover property (req_valid && req_write && req_src[3]);
  c_block: cover property (iou_mmio_block);
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cgc_pkg::*;
  localparam int NC = 4;
  localparam int NI = 2;
  localparam int NM = 3;
  localparam int NA = 2;
  localparam int NCL = 2;
  localparam int CID = 'h5a;
  localparam int NP = 1;
  localparam int NOC = 3;
  localparam bit ITC = 1'b1;
  localparam bit DBU = 1'b1;
  localparam bit CUS = 1'b1;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] sw_addr = 18'h0;
  logic [63:0] sw_wdata = 64'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [3:0] sw_src = 4'h0;
  logic [63:0] sw_rdata;
  logic sem_acquired;
  logic [63:0] exp_q[$];
  logic [63:0] d;
  logic [63:0] v;
  int err_total = 0;
  int checks_done = 0;
  cgc_if bus ();
  always #25 mclk = ~mclk;
  cgc_regs #(.NUM_CORES(NC), .NUM_IOU(NI), .NUM_MMIO(NM), .NUM_AUX(NA),
    .NUM_CLUSTERS(NCL), .CLUSTER_ID(CID), .NUM_PFT(NP), .ITC_PRESENT(ITC),
    .DBU_PRESENT(DBU), .NOC_TYPE(NOC), .CUSTOM_PRESENT(CUS))
    cgc_regs_i (.mclk(mclk), .rst_b(rst_b), .bus(bus));
  cgc_req cgc_req_i (.mclk(mclk), .rst_b(rst_b), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_src(sw_src),
    .sw_rdata(sw_rdata), .sem_acquired(sem_acquired), .bus(bus));
  cgc_assertions #(.NUM_CORES(NC), .NUM_IOU(NI), .NUM_PFT(NP))
    cgc_assertions_i (.mclk(mclk), .rst_b(rst_b),
    .req_valid(bus.req_valid), .req_write(bus.req_write),
    .req_src(bus.req_src), .req_addr(bus.req_addr),
    .req_wdata(bus.req_wdata), .rsp_valid(bus.rsp_valid),
    .rsp_rdata(bus.rsp_rdata), .iou_mmio_block(bus.iou_mmio_block),
    .iou_mmio_count(bus.iou_mmio_count), .pft_enable(bus.pft_enable),
    .pft_code_en(bus.pft_code_en), .pft_port_sel(bus.pft_port_sel),
    .coherence_enable(bus.coherence_enable));
  // ****
  // helpers
  // ****
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task op(input logic w, input logic [17:0] a, input logic [63:0] dd,
      input logic [3:0] s, input logic [63:0] e);
    @(posedge mclk);
    sw_wr <= w;
    sw_rd <= !w;
    sw_addr <= a;
    sw_wdata <= dd;
    sw_src <= s;
    if (!w)
      exp_q.push_back(e);
  endtask
  task wr(input logic [17:0] a, input logic [63:0] dd, input logic [3:0] s);
    op(1'b1, a, dd, s, 64'h0);
  endtask
  task rd(input logic [17:0] a, input logic [63:0] e);
    op(1'b0, a, 64'h0, 4'h0, e);
  endtask
  task idle();
    @(posedge mclk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(negedge mclk);
  endtask
  task finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // read answers are compared oldest first
  always @(negedge mclk) begin
    if (bus.rsp_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("spurious", 64'h0, 64'h1);
      else
        chk("rdata", exp_q.pop_front(), sw_rdata);
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h55632cbf));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    d = {$urandom, $urandom};
    rd(OFS_BASE, BASE_RST);
    wr(OFS_CONFIG, d, 4'h0);
    rd(OFS_CONFIG, {20'h0, 3'(NOC), DBU, 8'(CID), ITC, 1'b0, 7'(NCL),
      3'(NA), 4'(NM), 4'h0, 4'(NI), 8'(NC)});
    wr(OFS_BASE, d, 4'h0);
    rd(OFS_BASE, d & 64'h0000_ffff_fff8_0000);
    rd(OFS_CUSTOM, 64'(CUS));
    rd(18'h00abc, 64'h0);
    wr(OFS_PFT_A, 64'h100, 4'h0);
    rd(OFS_PFT_A, 64'h100 | 64'(NP));
    wr(OFS_PFT_B, d, 4'h0);
    rd(OFS_PFT_B, {55'h0, d[8], d[7:0] & 8'h3f});
    idle();
    chk("pft_en", 64'h1, 64'(bus.pft_enable));
    chk("port_sel", 64'(d[7:0] & 8'h3f), 64'(bus.pft_port_sel));
    chk("code_en", 64'(d[8]), 64'(bus.pft_code_en));
    for (int i = 0; i < 4; i++) begin
      v = 64'(i) << 12;
      wr(OFS_CONTROL, v, 4'h0);
      idle();
      chk("block", 64'(v[13]), 64'(bus.iou_mmio_block));
      chk("count", 64'(v[12] & !v[13]), 64'(bus.iou_mmio_count));
    end
    wr(OFS_CONTROL, 64'h0, 4'h9);
    idle();
    chk("deny", 64'h1, 64'(bus.iou_mmio_block));
    wr(OFS_ACCESS, 64'h2_0000, 4'h0);
    rd(OFS_ACCESS, 64'h2_0000);
    wr(OFS_CONTROL, 64'h0, 4'h9);
    idle();
    chk("allow", 64'h0, 64'(bus.iou_mmio_block));
    for (int i = 0; i < NC; i++) begin
      wr(OFS_COH + 18'(i * 256), 64'h1, 4'h0);
      idle();
      chk("coh", 64'((1 << (i + 1)) - 1), 64'(bus.coherence_enable));
    end
    rd(OFS_COH + 18'h300, 64'h1);
    rd(OFS_COH + 18'h400, 64'h0);
    v = {32'h0, 32'h8000_0000 | 32'($urandom_range(255))};
    wr(OFS_SEM, v, 4'h0);
    rd(OFS_SEM, v);
    idle();
    repeat (2) @(negedge mclk);
    chk("acquired", 64'h1, 64'(sem_acquired));
    wr(OFS_SEM, v ^ 64'h5, 4'h0);
    rd(OFS_SEM, v);
    idle();
    @(negedge mclk);
    chk("lost", 64'h0, 64'(sem_acquired));
    wr(OFS_SEM, 64'h0, 4'h0);
    rd(OFS_SEM, 64'h0);
    wr(OFS_SEM, v ^ 64'h5, 4'h0);
    rd(OFS_SEM, v ^ 64'h5);
    idle();
    for (int i = 0; i < 20 && exp_q.size() > 0; i++)
      @(negedge mclk);
    if (exp_q.size() > 0)
      chk("drain", 64'h0, 64'h1);
    finish_test();
  end
endmodule
`default_nettype wire
